// ===== src/pll_cfg_defines.svh
// Notes on behaviour
// - With bit 26 set, a reference/leakage write waits in shadow until master write.
// - Bit 25 shuts down every function block except the voltage regulators; here it gates oscillators, RF outputs, divider and lock detector only.
// - Bit 24 picks leakage step: clear 10 uA per code, set 20 uA.
// - Leakage magnitude bits 23:19 give code times step; zero means no leakage.
// - Bit 18 sets leakage direction: clear sinks current, set sources it.
// - Bit 17 enables down-split pulse; size comes from the master delay field.
// - Bits 16:15 select delay path: none, feedback, reference, reserved.
// - Bits 14:13 select reference path: direct, doubled, halved, quartered.
// - Reference is divided by the 13-bit ratio; host programs 1 to 8191.
// - Bit 19 enables external oscillator buffer and powers down internal oscillators.
// - Bit 11 clear auto-adjusts pump current; set fixes it by master code.
// - Bit 10 selects comparator polarity: clear standard, set inverted.
// - Bits 9:8 select reference buffer: differential, crystal, single-ended; 00 reserved.
// - Bit 7 set turns RF outputs off whenever the loop is unlocked.
// - Bit 6 set makes the lock indicator low when locked.
// - Lock window is 2 ns times code plus one, 2 to 16 ns.
// - Lock count codes map to 4, 8, 16, 64, 256, 1024, 2048, 4096.
// - Master delay codes give 1.2/1.9/2.5/3.0 ns and 0/0.25/0.5/0.75 split.
`ifndef PLL_CFG_DEFINES_SVH
`define PLL_CFG_DEFINES_SVH

`define ADDR_W          4
`define REG_W           27
`define REG_RESET       27'h0000000
`define OFS_MASTER      4'h0
`define OFS_REF_LEAK    4'h3
`define OFS_LOCK_OSC    4'h4

`define B_SHADOW_EN     26
`define B_SHUTDOWN      25
`define B_LEAK_X2       24
`define F_LEAK          23:19
`define B_LEAK_DIR      18
`define B_SPLIT_EN      17
`define F_DPATH         16:15
`define F_RPATH         14:13
`define F_RATIO         12:0

`define B_CAL_HI        24
`define B_OUT_LOW       23
`define B_EXT_OSC       19
`define F_AMP           17:15
`define B_CAL_LO        14
`define B_CAL_MODE      12
`define B_GAIN_DIS      11
`define B_POL           10
`define F_RBUF          9:8
`define B_MUTE          7
`define B_LD_INV        6
`define F_WIN           5:3
`define F_CNT           2:0

`define F_PUMP          25:21
`define F_DELAY         20:19

`define RATIO_W         13
`define LEAK_STEP_UA    10'h00a
`define WIN_STEP_PS     16'h07d0
`define DELAY_PS_0      12'h4b0
`define DELAY_PS_1      12'h76c
`define DELAY_PS_2      12'h9c4
`define DELAY_PS_3      12'hbb8
`define LOCK_CNT_0      13'h0004
`define LOCK_CNT_1      13'h0008
`define LOCK_CNT_2      13'h0010
`define LOCK_CNT_3      13'h0040
`define LOCK_CNT_4      13'h0100
`define LOCK_CNT_5      13'h0400
`define LOCK_CNT_6      13'h0800
`define LOCK_CNT_7      13'h1000

`endif

// ===== src/pll_cfg_pkg.sv
`include "pll_cfg_defines.svh"
`default_nettype none
package pll_cfg_pkg;
  typedef enum logic [1:0] {
    DPATH_NONE = 2'b00, DPATH_FEEDBACK = 2'b01, DPATH_REFERENCE = 2'b10, DPATH_RSVD = 2'b11
  } delay_path_t;
  typedef enum logic [1:0] {
    RPATH_DIRECT = 2'b00, RPATH_DOUBLED = 2'b01, RPATH_HALF = 2'b10, RPATH_QUARTER = 2'b11
  } ref_path_t;
  typedef enum logic [1:0] {
    RBUF_RSVD = 2'b00, RBUF_DIFF = 2'b01, RBUF_XTAL = 2'b10, RBUF_SINGLE = 2'b11
  } refbuf_mode_t;
  typedef enum logic [1:0] {
    LK_UNLOCKED = 2'b00, LK_COUNTING = 2'b01, LK_LOCKED = 2'b10
  } lock_state_t;

  typedef struct packed {
    logic [`RATIO_W-1:0] cnt;
    logic                tick;
  } div_state_t;

  typedef struct packed {
    logic [`REG_W-1:0]   ref_wr;
    logic [`REG_W-1:0]   ref_act;
    logic [`REG_W-1:0]   lock_wr;
    logic                pending;
    logic [1:0]          delay_amt;
    logic [4:0]          pump_code;
    lock_state_t         lock_st;
    logic [12:0]         lock_cnt;
    logic [`REG_W-1:0]   rd_data;
    logic                rd_valid;
    logic                shutdown;
    logic [9:0]          leak_ua;
    logic                leak_dir;
    logic [1:0]          split_level;
    logic [11:0]         delay_ps;
    delay_path_t         dpath;
    ref_path_t           rpath;
    logic [`RATIO_W-1:0] ratio;
    logic                ext_osc;
    logic                int_osc;
    logic [2:0]          amp;
    logic [1:0]          cal_supply;
    logic                cal_mode;
    logic                out_low;
    logic                gain_comp;
    logic                pol_inv;
    refbuf_mode_t        refbuf;
    logic                rf_off;
    logic                lock_ind;
  } cfg_state_t;
endpackage
`default_nettype wire

// ===== src/pll_refpath_lockdetect_config.sv
`include "pll_cfg_defines.svh"
`default_nettype none
module pll_refpath_lockdetect_config (
  input  wire logic                     core_clk,         // 10 MHz clock
  input  wire logic                     reset_n,          // Async reset, active low
  input  wire logic                     wr_en,            // Register write strobe
  input  wire logic [`ADDR_W-1:0]       wr_addr,          // Write address
  input  wire logic [`REG_W-1:0]        wr_data,          // Write data
  input  wire logic                     rd_en,            // Register read strobe
  input  wire logic [`ADDR_W-1:0]       rd_addr,          // Read address
  output logic [`REG_W-1:0]             rd_data,          // Read data
  output logic                          rd_valid,         // Read data valid pulse
  input  wire logic                     ref_tick,         // Reference edge enable
  output logic                          ref_div_tick,     // Divided reference pulse
  input  wire logic                     cmp_valid,        // Phase comparison done
  input  wire logic [15:0]              phase_err_ps,     // Phase error magnitude, ps
  output logic                          update_pending,   // Shadow awaits master write
  output logic                          global_shutdown,  // All blocks off
  output logic [9:0]                    leak_current_ua,  // Leakage current, uA
  output logic                          leak_direction,   // 1 source, 0 sink
  output logic [1:0]                    split_level,      // Split current, quarters
  output logic [11:0]                   delay_ps,         // Anti-backlash delay, ps
  output pll_cfg_pkg::delay_path_t      comparator_delay_path, // Delayed path
  output pll_cfg_pkg::ref_path_t        ref_path,         // Reference path mode
  output logic [`RATIO_W-1:0]           ref_ratio,        // Active divider ratio
  output logic                          external_oscillator_enable, // Ext buffer on
  output logic                          internal_osc_enable,        // Internal cores on
  output logic [2:0]                    oscillator_amplitude,       // Amplitude code
  output logic [1:0]                    cal_supply_mode,  // {hi, lo} supply bits
  output logic                          calibrator_mode,  // Calibrator mode bit
  output logic                          output_supply_low, // Output supply bit
  output logic                          gain_comp_enable, // Pump auto-adjust on
  output logic [4:0]                    pump_current_code, // Master pump code
  output logic                          comparator_polarity, // 1 inverted
  output pll_cfg_pkg::refbuf_mode_t     reference_buffer_mode, // Buffer mode
  output logic                          rf_output_off,    // RF stages muted
  output logic                          lock_indicator    // Lock pin level
);
  import pll_cfg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [12:0] lock_target(input logic [2:0] code);
    case (code)
      3'h0:    lock_target = `LOCK_CNT_0;
      3'h1:    lock_target = `LOCK_CNT_1;
      3'h2:    lock_target = `LOCK_CNT_2;
      3'h3:    lock_target = `LOCK_CNT_3;
      3'h4:    lock_target = `LOCK_CNT_4;
      3'h5:    lock_target = `LOCK_CNT_5;
      3'h6:    lock_target = `LOCK_CNT_6;
      default: lock_target = `LOCK_CNT_7;
    endcase
  endfunction

  function automatic logic [15:0] window_ps(input logic [2:0] code);
    window_ps = 16'({13'h0000, code} + 16'h0001) * `WIN_STEP_PS;
  endfunction

  function automatic logic [11:0] delay_of(input logic [1:0] code);
    case (code)
      2'h0:    delay_of = `DELAY_PS_0;
      2'h1:    delay_of = `DELAY_PS_1;
      2'h2:    delay_of = `DELAY_PS_2;
      default: delay_of = `DELAY_PS_3;
    endcase
  endfunction

  function automatic logic [9:0] leak_of(input logic [4:0] mag, input logic x2);
    leak_of = 10'(mag) * (x2 ? (`LEAK_STEP_UA << 1) : `LEAK_STEP_UA);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  cfg_state_t s_q;
  cfg_state_t s_d;
  logic       in_window;
  logic       locked_q;
  logic [12:0] cnt_inc;
  logic       div_tick;

  assign in_window = phase_err_ps <= window_ps(s_q.lock_wr[`F_WIN]);
  assign locked_q  = (s_q.lock_st == LK_LOCKED);
  assign cnt_inc   = s_q.lock_cnt + 13'h0001;

  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;

    // Register writes
    if (wr_en) begin
      case (wr_addr)
        `OFS_MASTER: begin
          s_d.delay_amt = wr_data[`F_DELAY];
          s_d.pump_code = wr_data[`F_PUMP];
          if (s_q.pending) begin
            s_d.ref_act = s_q.ref_wr;
            s_d.pending = 1'b0;
          end
        end
        `OFS_REF_LEAK: begin
          s_d.ref_wr = wr_data;
          if (wr_data[`B_SHADOW_EN]) begin
            s_d.pending = 1'b1;
          end else begin
            s_d.ref_act = wr_data;
            s_d.pending = 1'b0;
          end
        end
        // Reserved bits stored as written; host keeps them zero
        `OFS_LOCK_OSC: s_d.lock_wr = wr_data;
        default: ;
      endcase
    end

    // Read back of reference/leakage and lock words, shadow included; others read zero
    if (rd_en) begin
      s_d.rd_valid = 1'b1;
      case (rd_addr)
        `OFS_REF_LEAK: s_d.rd_data = s_q.ref_wr;
        `OFS_LOCK_OSC: s_d.rd_data = s_q.lock_wr;
        default:       s_d.rd_data = `REG_RESET;
      endcase
    end

    // Lock detector; shutdown forces it back to unlocked
    case (s_q.lock_st)
      LK_UNLOCKED: begin
        s_d.lock_cnt = '0;
        if (cmp_valid && in_window) begin
          s_d.lock_st  = LK_COUNTING;
          s_d.lock_cnt = 13'h0001;
        end
      end
      LK_COUNTING: begin
        if (cmp_valid) begin
          if (!in_window) begin
            s_d.lock_st  = LK_UNLOCKED;
            s_d.lock_cnt = '0;
          end else if (cnt_inc >= lock_target(s_q.lock_wr[`F_CNT])) begin
            s_d.lock_st  = LK_LOCKED;
            s_d.lock_cnt = '0;
          end else begin
            s_d.lock_cnt = cnt_inc;
          end
        end
      end
      LK_LOCKED: begin
        if (cmp_valid && !in_window) begin
          s_d.lock_st = LK_UNLOCKED;
        end
      end
      default: begin
        s_d.lock_st  = LK_UNLOCKED;
        s_d.lock_cnt = '0;
      end
    endcase
    if (s_q.shutdown) begin
      s_d.lock_st  = LK_UNLOCKED;
      s_d.lock_cnt = '0;
    end

    // Decoded controls from the next active copy, so they move with it
    s_d.shutdown    = s_d.ref_act[`B_SHUTDOWN];
    s_d.leak_ua     = leak_of(s_d.ref_act[`F_LEAK], s_d.ref_act[`B_LEAK_X2]);
    s_d.leak_dir    = s_d.ref_act[`B_LEAK_DIR];
    s_d.split_level = s_d.ref_act[`B_SPLIT_EN] ? s_d.delay_amt : 2'h0;
    s_d.delay_ps    = delay_of(s_d.delay_amt);
    s_d.dpath       = delay_path_t'(s_d.ref_act[`F_DPATH]);
    // Doubling is analogue; only the mode is passed on
    s_d.rpath       = ref_path_t'(s_d.ref_act[`F_RPATH]);
    s_d.ratio       = s_d.ref_act[`F_RATIO];
    s_d.ext_osc     = s_d.lock_wr[`B_EXT_OSC] && !s_d.shutdown;
    s_d.int_osc     = !s_d.lock_wr[`B_EXT_OSC] && !s_d.shutdown;
    s_d.amp         = s_d.lock_wr[`F_AMP];
    s_d.cal_supply  = {s_d.lock_wr[`B_CAL_HI], s_d.lock_wr[`B_CAL_LO]};
    s_d.cal_mode    = s_d.lock_wr[`B_CAL_MODE];
    s_d.out_low     = s_d.lock_wr[`B_OUT_LOW];
    s_d.gain_comp   = !s_d.lock_wr[`B_GAIN_DIS];
    s_d.pol_inv     = s_d.lock_wr[`B_POL];
    s_d.refbuf      = refbuf_mode_t'(s_d.lock_wr[`F_RBUF]);
    s_d.rf_off      = s_d.shutdown ||
                      (s_d.lock_wr[`B_MUTE] && (s_d.lock_st != LK_LOCKED));
    s_d.lock_ind    = (s_d.lock_st == LK_LOCKED) ^ s_d.lock_wr[`B_LD_INV];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference divider, held cleared while shut down

  ref_ratio_divider #(
    .WIDTH (`RATIO_W)
  ) u_ref_div (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .enable   (!s_q.shutdown),
    .tick_in  (ref_tick),
    .ratio    (s_q.ratio),
    .tick_out (div_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data                    = s_q.rd_data;
  assign rd_valid                   = s_q.rd_valid;
  assign ref_div_tick               = div_tick;
  assign update_pending             = s_q.pending;
  assign global_shutdown            = s_q.shutdown;
  assign leak_current_ua            = s_q.leak_ua;
  assign leak_direction             = s_q.leak_dir;
  assign split_level                = s_q.split_level;
  assign delay_ps                   = s_q.delay_ps;
  assign comparator_delay_path      = s_q.dpath;
  assign ref_path                   = s_q.rpath;
  assign ref_ratio                  = s_q.ratio;
  assign external_oscillator_enable = s_q.ext_osc;
  assign internal_osc_enable        = s_q.int_osc;
  assign oscillator_amplitude       = s_q.amp;
  assign cal_supply_mode            = s_q.cal_supply;
  assign calibrator_mode            = s_q.cal_mode;
  assign output_supply_low          = s_q.out_low;
  assign gain_comp_enable           = s_q.gain_comp;
  assign pump_current_code          = s_q.pump_code;
  assign comparator_polarity        = s_q.pol_inv;
  assign reference_buffer_mode      = s_q.refbuf;
  assign rf_output_off              = s_q.rf_off;
  assign lock_indicator             = s_q.lock_ind;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_shadow_write;
    wr_en && wr_addr == `OFS_REF_LEAK && wr_data[`B_SHADOW_EN];
  endsequence
  sequence seq_master_write;
    wr_en && wr_addr == `OFS_MASTER;
  endsequence

  a_shadow_holds: assert property (
    seq_shadow_write |=> $stable(s_q.ref_act) && update_pending
  ) else $error("shadowed write changed active copy");

  a_master_commits: assert property (
    seq_master_write ##0 update_pending |=> s_q.ref_act == $past(s_q.ref_wr) && !update_pending
  ) else $error("master write did not apply shadow");

  a_plain_write: assert property (
    wr_en && wr_addr == `OFS_REF_LEAK && !wr_data[`B_SHADOW_EN]
      |=> s_q.ref_act == $past(wr_data) && !update_pending
  ) else $error("direct write not applied");

  a_shutdown_off: assert property (
    global_shutdown |-> !internal_osc_enable && !external_oscillator_enable && rf_output_off
  ) else $error("block still on during shutdown");

  a_leak_value: assert property (
    leak_current_ua == 10'(s_q.ref_act[`F_LEAK]) * (s_q.ref_act[`B_LEAK_X2] ? 10'd20 : 10'd10)
  ) else $error("leakage current mismatch");

  a_split_gate: assert property (
    !s_q.ref_act[`B_SPLIT_EN] |-> split_level == 2'h0
  ) else $error("split current without enable");

  a_lock_drop: assert property (
    locked_q && cmp_valid && !in_window && !s_q.shutdown |=> !locked_q ##1 !locked_q
  ) else $error("lock kept after miss");

  a_count_restart: assert property (
    s_q.lock_st == LK_COUNTING && cmp_valid && !in_window
      |=> s_q.lock_st == LK_UNLOCKED && s_q.lock_cnt == 13'h0000
  ) else $error("count kept after miss");

  a_lock_count: assert property (
    $rose(locked_q) |-> $past(cmp_valid) &&
      $past(s_q.lock_cnt) + 13'h0001 >= $past(lock_target(s_q.lock_wr[`F_CNT]))
  ) else $error("lock declared early");

  a_lock_polarity: assert property (
    lock_indicator == (locked_q ^ s_q.lock_wr[`B_LD_INV])
  ) else $error("lock indicator polarity wrong");

  a_mute_unlock: assert property (
    s_q.lock_wr[`B_MUTE] && !locked_q |-> rf_output_off
  ) else $error("output not muted while unlocked");

  a_read_back: assert property (
    rd_en && rd_addr == `OFS_REF_LEAK |=> rd_valid && rd_data == $past(s_q.ref_wr)
  ) else $error("read back mismatch");

  a_read_lock: assert property (
    rd_en && rd_addr == `OFS_LOCK_OSC |=> rd_valid && rd_data == $past(s_q.lock_wr)
  ) else $error("lock register read back mismatch");
endmodule // pll_refpath_lockdetect_config
`default_nettype wire

// ===== src/ref_ratio_divider.sv
`include "pll_cfg_defines.svh"
`default_nettype none
module ref_ratio_divider #(
  parameter int WIDTH = `RATIO_W
) (
  input  wire logic             core_clk,  // System clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic             enable,    // Low holds divider cleared
  input  wire logic             tick_in,   // Reference edge enable
  input  wire logic [WIDTH-1:0] ratio,     // Division ratio
  output logic                  tick_out   // One pulse per ratio ticks
);
  import pll_cfg_pkg::*;

  div_state_t s_q;
  div_state_t s_d;
  logic [WIDTH-1:0] next_cnt;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    next_cnt = s_q.cnt + WIDTH'(1);
    if (!enable) begin
      s_d.cnt = '0;
    end else if (tick_in) begin
      // Ratio zero behaves as one rather than stalling
      if (next_cnt >= ratio) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = next_cnt;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;
endmodule // ref_ratio_divider
`default_nettype wire

// ===== test/pll_cfg_host.sv
`include "pll_cfg_defines.svh"
`default_nettype none
module pll_cfg_host (
  input  wire logic              core_clk,  // System clock
  output logic                   wr_en,     // Write strobe
  output logic [`ADDR_W-1:0]     wr_addr,   // Write address
  output logic [`REG_W-1:0]      wr_data,   // Write data
  output logic                   rd_en,     // Read strobe
  output logic [`ADDR_W-1:0]     rd_addr,   // Read address
  input  wire logic [`REG_W-1:0] rd_data,   // Read data
  input  wire logic              rd_valid   // Read data valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 4'h0;
    rd_addr = 4'h0;
    wr_data = 27'h0000000;
  end
  ////////////////////////////////////////////////////////////////////////
  // Idle bus shows the inverse of the last word, never a stale copy
  task automatic write_reg(input logic [`ADDR_W-1:0] a, input logic [`REG_W-1:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic read_reg(input logic [`ADDR_W-1:0] a, output logic [`REG_W-1:0] d,
                          output logic v);
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    // Sampled mid-cycle, while the one-cycle answer stands
    @(negedge core_clk);
    v = rd_valid;
    d = rd_data;
  endtask
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [`REG_W-1:0] legal_ref(input logic [`REG_W-1:0] r);
    logic [`REG_W-1:0] w;
    w = r;
    if (w[12:0] == 13'h0000) w[12:0] = 13'h0001;
    return w;
  endfunction
  function automatic logic [`REG_W-1:0] legal_lock(input logic [`REG_W-1:0] r,
                                                   input logic core_3v3, input logic out_3v3);
    logic [`REG_W-1:0] w;
    w = r;
    w[26:25] = 2'b00;
    w[22:20] = 3'h0;
    w[18] = 1'b0;
    w[13] = 1'b0;
    if (core_3v3 && w[17:15] > 3'h2) w[17:15] = 3'h2;
    w[24] = core_3v3;
    w[14] = core_3v3;
    if (core_3v3) w[12] = 1'b1;
    w[23] = out_3v3;
    if (w[9:8] == 2'b00) w[9:8] = 2'b01;
    return w;
  endfunction
endmodule // pll_cfg_host
`default_nettype wire

// ===== test/pll_refpath_lockdetect_config_tb_top.sv
`include "pll_cfg_defines.svh"
`default_nettype none
module pll_refpath_lockdetect_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pll_cfg_pkg::*;
  logic core_clk, reset_n, wr_en, rd_en, rd_valid, ref_tick, ref_div_tick, cmp_valid;
  logic update_pending, global_shutdown, leak_direction, external_oscillator_enable;
  logic internal_osc_enable, calibrator_mode, output_supply_low, gain_comp_enable;
  logic comparator_polarity, rf_output_off, lock_indicator;
  logic [3:0]   wr_addr, rd_addr;
  logic [26:0]  wr_data, rd_data, ref_m, lock_m, w, d;
  logic [15:0]  phase_err_ps;
  logic [9:0]   leak_current_ua;
  logic [1:0]   split_level, cal_supply_mode, dly_m;
  logic [11:0]  delay_ps;
  logic [12:0]  ref_ratio;
  logic [2:0]   oscillator_amplitude;
  logic [4:0]   pump_current_code, pump_m;
  logic         v, sd, lk;
  delay_path_t  comparator_delay_path;
  ref_path_t    ref_path;
  refbuf_mode_t reference_buffer_mode;
  int mismatches, total_checks, n, lim, pulses;
  int cnt_tab[8] = '{4, 8, 16, 64, 256, 1024, 2048, 4096};
  int dly_tab[4] = '{1200, 1900, 2500, 3000};
  pll_refpath_lockdetect_config dut (
    .core_clk(core_clk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .ref_tick(ref_tick), .ref_div_tick(ref_div_tick),
    .cmp_valid(cmp_valid), .phase_err_ps(phase_err_ps), .update_pending(update_pending),
    .global_shutdown(global_shutdown), .leak_current_ua(leak_current_ua),
    .leak_direction(leak_direction), .split_level(split_level), .delay_ps(delay_ps),
    .comparator_delay_path(comparator_delay_path), .ref_path(ref_path),
    .ref_ratio(ref_ratio), .external_oscillator_enable(external_oscillator_enable),
    .internal_osc_enable(internal_osc_enable), .oscillator_amplitude(oscillator_amplitude),
    .cal_supply_mode(cal_supply_mode), .calibrator_mode(calibrator_mode),
    .output_supply_low(output_supply_low), .gain_comp_enable(gain_comp_enable),
    .pump_current_code(pump_current_code), .comparator_polarity(comparator_polarity),
    .reference_buffer_mode(reference_buffer_mode), .rf_output_off(rf_output_off),
    .lock_indicator(lock_indicator)
  );
  pll_cfg_host host (
    .core_clk(core_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [26:0] exp);
    host.read_reg(a, d, v);
    chk({4'h0, v, d}, {5'h01, exp});
  endtask
  task automatic check_all();
    @(negedge core_clk);
    sd = ref_m[25];
    chk({global_shutdown, leak_current_ua, leak_direction},
        {sd, 10'(ref_m[23:19] * (ref_m[24] ? 20 : 10)), ref_m[18]});
    chk({comparator_delay_path, ref_path, ref_ratio}, ref_m[16:0]);
    chk({split_level, delay_ps}, {ref_m[17] ? dly_m : 2'b00, 12'(dly_tab[dly_m])});
    chk(pump_current_code, pump_m);
    chk({external_oscillator_enable, internal_osc_enable, rf_output_off},
        {lock_m[19] & ~sd, ~lock_m[19] & ~sd, sd | lock_m[7]});
    chk({oscillator_amplitude, cal_supply_mode, calibrator_mode},
        {lock_m[17:15], lock_m[24], lock_m[14], lock_m[12]});
    chk({output_supply_low, gain_comp_enable, comparator_polarity},
        {lock_m[23], ~lock_m[11], lock_m[10]});
    chk({reference_buffer_mode, lock_indicator}, {lock_m[9:8], lock_m[6]});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
  initial begin
    reset_n = 1'b0;
    ref_tick = 1'b0;
    cmp_valid = 1'b0;
    phase_err_ps = 16'h0000;
    {ref_m, lock_m, dly_m, pump_m} = '0;
    void'($urandom(9));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check_all();
    repeat (6) begin
      w = host.legal_ref(27'($urandom) & 27'h3ffffff);
      host.write_reg(4'h3, w);
      ref_m = w;
      check_all();
      chk_rd(4'h3, w);
      w = host.legal_lock(27'($urandom), 1'($urandom), 1'($urandom));
      host.write_reg(4'h4, w);
      lock_m = w;
      check_all();
      chk_rd(4'h4, w);
    end
    // Shadowed update must hold back until the master word lands
    w = 27'($urandom);
    host.write_reg(4'h0, w);
    {pump_m, dly_m} = w[25:19];
    check_all();
    w = host.legal_ref({2'b10, 25'($urandom)});
    host.write_reg(4'h3, w);
    @(negedge core_clk);
    chk(update_pending, 1);
    check_all();
    chk_rd(4'h3, w);
    chk_rd(4'h0, 27'h0000000);
    chk_rd(4'h7, 27'h0000000);
    host.write_reg(4'h9, 27'($urandom));
    host.write_reg(4'h0, {1'b0, ~pump_m, ~dly_m, 19'h00000});
    {pump_m, dly_m} = {~pump_m, ~dly_m};
    ref_m = w;
    @(negedge core_clk);
    chk(update_pending, 0);
    check_all();
    for (int c = 0; c < 8; c++) begin
      w = host.legal_lock(27'($urandom), 1'($urandom), 1'($urandom));
      w[7] = 1'b1;
      w[2:0] = 3'(c);
      host.write_reg(4'h4, w);
      lock_m = w;
      n = cnt_tab[c];
      lim = (int'(w[5:3]) + 1) * 2000;
      // One hit on the window edge, then a miss, so the run restarts from zero
      @(posedge core_clk);
      cmp_valid <= 1'b1;
      phase_err_ps <= 16'(lim);
      @(posedge core_clk);
      phase_err_ps <= 16'(lim + 1);
      for (int i = 0; i <= n; i++) begin
        @(posedge core_clk);
        cmp_valid <= (i < n);
        phase_err_ps <= 16'($urandom_range(lim, lim - 300));
        @(negedge core_clk);
        lk = (i == n);
        chk({lock_indicator, rf_output_off}, {lk ^ w[6], ~lk});
      end
      @(posedge core_clk);
      cmp_valid <= 1'b1;
      phase_err_ps <= 16'(lim + 1);
      @(posedge core_clk);
      cmp_valid <= 1'b0;
      check_all();
    end
    n = $urandom_range(5, 1);
    w = {14'h0000, 13'(n)};
    host.write_reg(4'h3, w);
    ref_m = w;
    pulses = 0;
    for (int i = 0; i < 3 * n + 2; i++) begin
      @(posedge core_clk);
      ref_tick <= (i < 3 * n);
      @(negedge core_clk);
      pulses += int'(ref_div_tick);
    end
    chk(pulses, 3);
    complete_run();
  end
endmodule // pll_refpath_lockdetect_config_tb_top
`default_nettype wire
